// *** rdimm_pkg.sv ***
// rdimm_pkg: shared constants for the registered command input stage.
// assumes both ends run on ref_clk (40 MHz) and meet through cmd_link_if.
//
// Behaviour
// R1: reset low forces registered outputs low asynchronously
// R2: controller may hold reset low at power-up
// R3: command = select, row, column, write strobe levels
// R4: inputs sampled on rising clock crossing
// R5: output data timed to clock crossings
// R6: clock enable high activates clock, buffers, drivers
// R7: enable low: precharge/self-refresh or active power-down
// R8: enable sampled for power-down and self-refresh entry
// R9: self-refresh exit and output disable are asynchronous
// R10: controller holds enable high during reads, writes
// R11: power-down disables buffers except clocks, enable
// R12: self refresh disables all buffers except enable
// R13: select low enables decoder, high disables it
// R14: select high masks every command
// R15: select is part of the command code
// R16: bank inputs choose target bank of command
// R17: inputs pass through one-clock register
// R18: controller expects read data one clock later
// R19: precharge address bit ten chooses one/all banks
// R20: bank inputs choose mode or extended mode register
package rdimm_pkg;
	localparam int ADDR_W = 13;
	localparam int BANK_W = 2;
	localparam int NUM_BANKS = 4;
	localparam int AP_BIT = 10;
	localparam int CAS_LAT = 3;
	// command code {sel_n, row_n, col_n, wr_n}
	localparam logic [3:0] CMD_DESEL = 4'h8;
	localparam logic [3:0] CMD_MRS = 4'h0;
	localparam logic [3:0] CMD_REF = 4'h1;
	localparam logic [3:0] CMD_PRE = 4'h2;
	localparam logic [3:0] CMD_ACT = 4'h3;
	localparam logic [3:0] CMD_WR = 4'h4;
	localparam logic [3:0] CMD_RD = 4'h5;
	localparam logic [3:0] CMD_NOP = 4'h7;
	localparam logic [1:0] MR_BASE = 2'h0;
	localparam logic [1:0] MR_EXT = 2'h1;
	typedef enum logic [1:0] {PWR_ACTIVE, PWR_PDN_PRE, PWR_PDN_ACT, PWR_SELF_REF} pwr_type;
endpackage : rdimm_pkg

// *** cmd_link_if.sv ***
// cmd_link_if: command/address pins between controller and module.
// assumes one shared clock; no two-way pins are carried here.
`timescale 1ns/1ps
`default_nettype none
interface cmd_link_if;
	logic rst_n;
	logic sel_n;
	logic row_n;
	logic col_n;
	logic wr_n;
	logic clk_en;
	logic [rdimm_pkg::BANK_W-1:0] bank;
	logic [rdimm_pkg::ADDR_W-1:0] addr;
	modport ctrl (output rst_n, output sel_n, output row_n, output col_n, output wr_n,
		output clk_en, output bank, output addr);
	modport dimm (input rst_n, input sel_n, input row_n, input col_n, input wr_n,
		input clk_en, input bank, input addr);
endinterface : cmd_link_if
`default_nettype wire

// *** rdimm_ctrl_end.sv ***
// rdimm_ctrl_end: controller end driving the command pins from a user request.
// assumes user holds a request until accepted; one command per accepted cycle.
`timescale 1ns/1ps
`default_nettype none
module rdimm_ctrl_end (
	input wire logic ref_clk, // clock
	input wire logic nrst, // sync reset, active low
	cmd_link_if.ctrl link, // module pins
	input wire logic hold_reset, // keep module input register in reset
	input wire logic req_valid, // request present
	output logic req_ready, // request taken this cycle
	input wire logic [3:0] req_cmd, // command code incl. select
	input wire logic [rdimm_pkg::BANK_W-1:0] req_bank, // bank or mode register choice
	input wire logic [rdimm_pkg::ADDR_W-1:0] req_addr, // address
	input wire logic req_clk_en, // wanted clock enable level
	output logic rd_expect, // pulse: read data due now
	output logic [3:0] cmd_reg // last command driven
);
	localparam int RD_DELAY = rdimm_pkg::CAS_LAT + 1;
	logic [3:0] cmd_next;
	logic [rdimm_pkg::BANK_W-1:0] bank_reg;
	logic [rdimm_pkg::ADDR_W-1:0] addr_reg;
	logic cke_reg;
	logic rst_out_reg;
	logic [RD_DELAY-1:0] rd_pipe_reg;
	logic busy_access;
	wire is_rd = req_valid && (req_cmd == rdimm_pkg::CMD_RD);
	wire is_wr = req_valid && (req_cmd == rdimm_pkg::CMD_WR);
	// enable may drop only when no read is in flight
	assign busy_access = |rd_pipe_reg;
	wire cke_want = req_clk_en | busy_access | is_rd | is_wr; // R10
	assign req_ready = 1'b1;
	// select is bit 3 of every code driven out
	assign cmd_next = req_valid ? req_cmd : rdimm_pkg::CMD_NOP; // R3 R15
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			cmd_reg <= rdimm_pkg::CMD_DESEL;
			bank_reg <= '0;
			addr_reg <= '0;
			cke_reg <= 1'b0;
			rst_out_reg <= 1'b0;
			rd_pipe_reg <= '0;
		end else begin
			cmd_reg <= cmd_next;
			bank_reg <= req_bank; // R16 R20
			addr_reg <= req_addr; // R19
			cke_reg <= cke_want;
			rst_out_reg <= !hold_reset; // R2
			rd_pipe_reg <= {rd_pipe_reg[RD_DELAY-2:0], is_rd}; // R18
		end
	end
	assign rd_expect = rd_pipe_reg[RD_DELAY-1]; // R18
	assign link.rst_n = rst_out_reg;
	assign link.sel_n = cmd_reg[3];
	assign link.row_n = cmd_reg[2];
	assign link.col_n = cmd_reg[1];
	assign link.wr_n = cmd_reg[0];
	assign link.clk_en = cke_reg;
	assign link.bank = bank_reg;
	assign link.addr = addr_reg;
endmodule : rdimm_ctrl_end
`default_nettype wire

// *** rdimm_dimm_end.sv ***
// rdimm_dimm_end: module end; one-clock input register plus command decode.
// assumes pins are synchronous to ref_clk; reset pin clears the register
// asynchronously, nrst resets the tracking state synchronously.
`timescale 1ns/1ps
`default_nettype none
module rdimm_dimm_end (
	input wire logic ref_clk, // clock (rising crossing)
	input wire logic nrst, // sync reset, active low
	cmd_link_if.dimm link, // controller pins
	output logic [3:0] dev_cmd_reg, // registered command to devices
	output logic [rdimm_pkg::BANK_W-1:0] dev_bank_reg, // registered bank
	output logic [rdimm_pkg::ADDR_W-1:0] dev_addr_reg, // registered address
	output logic dev_cke_reg, // registered clock enable
	output logic dev_clk_on, // device internal clock running
	output logic cmd_buf_on, // command/address buffers on
	output logic clk_buf_on, // clock input buffers on
	output logic out_drv_on, // output drivers on
	output logic cmd_fire, // pulse: decoded command valid
	output logic [rdimm_pkg::NUM_BANKS-1:0] bank_hit, // banks the command hits
	output logic mr_ext_sel, // mode register write targets extended
	output rdimm_pkg::pwr_type pwr_state_reg, // power state
	output logic [rdimm_pkg::NUM_BANKS-1:0] open_rows_reg // banks with row open
);
	rdimm_pkg::pwr_type pwr_next;
	logic [rdimm_pkg::NUM_BANKS-1:0] open_next;
	wire [3:0] pin_cmd = {link.sel_n, link.row_n, link.col_n, link.wr_n}; // R3 R15
	// input register, one clock of delay
	always_ff @(posedge ref_clk or negedge link.rst_n) begin // R4 R17
		if (!link.rst_n) begin // R1
			dev_cmd_reg <= 4'h0;
			dev_bank_reg <= '0;
			dev_addr_reg <= '0;
			dev_cke_reg <= 1'b0;
		end else begin
			dev_cmd_reg <= pin_cmd;
			dev_bank_reg <= link.bank;
			dev_addr_reg <= link.addr;
			dev_cke_reg <= link.clk_en; // R8
		end
	end
	// ****************************************
	// decode
	// ****************************************
	wire dec_en = !dev_cmd_reg[3] && dev_cke_reg && link.rst_n; // R13 R14
	assign cmd_fire = dec_en && (pwr_state_reg == rdimm_pkg::PWR_ACTIVE);
	wire is_pre = cmd_fire && (dev_cmd_reg == rdimm_pkg::CMD_PRE);
	wire is_act = cmd_fire && (dev_cmd_reg == rdimm_pkg::CMD_ACT);
	wire is_ref = cmd_fire && (dev_cmd_reg == rdimm_pkg::CMD_REF);
	wire is_mrs = cmd_fire && (dev_cmd_reg == rdimm_pkg::CMD_MRS);
	wire all_pre = dev_addr_reg[rdimm_pkg::AP_BIT]; // R19
	wire [rdimm_pkg::NUM_BANKS-1:0] bank_one = rdimm_pkg::NUM_BANKS'(1) << dev_bank_reg; // R16
	assign bank_hit = !cmd_fire ? '0 : (is_pre && all_pre) ? '1 : bank_one; // R16 R19
	assign mr_ext_sel = is_mrs && (dev_bank_reg == rdimm_pkg::MR_EXT); // R20
	// ****************************************
	// bank and power tracking
	// ****************************************
	// refresh registered together with enable low means self-refresh entry;
	// the decoder is gated off by low enable, so this looks at the raw code
	wire sr_enter = !dev_cmd_reg[3] && (dev_cmd_reg == rdimm_pkg::CMD_REF) && !dev_cke_reg
		&& link.rst_n && (pwr_state_reg == rdimm_pkg::PWR_ACTIVE); // R7 R8
	always_comb begin
		open_next = open_rows_reg;
		if (is_act) open_next = open_rows_reg | bank_one;
		if (is_pre) open_next = open_rows_reg & ~bank_hit;
		pwr_next = pwr_state_reg;
		case (pwr_state_reg)
			rdimm_pkg::PWR_ACTIVE: begin // R7 R8
				if (sr_enter) pwr_next = rdimm_pkg::PWR_SELF_REF;
				else if (!dev_cke_reg && |open_rows_reg) pwr_next = rdimm_pkg::PWR_PDN_ACT;
				else if (!dev_cke_reg) pwr_next = rdimm_pkg::PWR_PDN_PRE;
			end
			rdimm_pkg::PWR_PDN_PRE, rdimm_pkg::PWR_PDN_ACT: begin // R8
				if (dev_cke_reg) pwr_next = rdimm_pkg::PWR_ACTIVE;
			end
			rdimm_pkg::PWR_SELF_REF: begin // R9
				if (link.clk_en) pwr_next = rdimm_pkg::PWR_ACTIVE;
			end
			default: pwr_next = rdimm_pkg::PWR_ACTIVE;
		endcase
	end
	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			pwr_state_reg <= rdimm_pkg::PWR_ACTIVE;
			open_rows_reg <= '0;
		end else begin
			pwr_state_reg <= pwr_next;
			open_rows_reg <= open_next;
		end
	end
	// ****************************************
	// gating
	// ****************************************
	// self-refresh exit and driver disable follow the pin with no clock edge
	wire in_sr = (pwr_state_reg == rdimm_pkg::PWR_SELF_REF) && !link.clk_en; // R9
	wire in_pd = (pwr_state_reg == rdimm_pkg::PWR_PDN_PRE)
		|| (pwr_state_reg == rdimm_pkg::PWR_PDN_ACT);
	assign dev_clk_on = dev_cke_reg && !in_sr && !in_pd; // R6
	assign cmd_buf_on = !in_pd && !in_sr && dev_cke_reg; // R6 R11 R12
	assign clk_buf_on = !in_sr; // R11 R12
	assign out_drv_on = link.clk_en && dev_cke_reg && !in_pd; // R5 R6 R9
endmodule : rdimm_dimm_end
`default_nettype wire

// *** rdimm_props.sv ***
// rdimm_props: concurrent checks on the command link and the module end.
// assumes one clock; the bench instantiates it beside the link.
`timescale 1ns/1ps
`default_nettype none
module rdimm_props (
	input wire logic ref_clk, // clock
	input wire logic nrst, // sync reset
	input wire logic rst_n, // clear pin
	input wire logic sel_n, // select pin
	input wire logic row_n, // row pin
	input wire logic col_n, // column pin
	input wire logic wr_n, // write pin
	input wire logic clk_en, // enable pin
	input wire logic [3:0] dev_cmd_reg, // reg command
	input wire logic [1:0] dev_bank_reg, // reg bank
	input wire logic [12:0] dev_addr_reg, // reg address
	input wire logic dev_cke_reg, // reg enable
	input wire logic cmd_fire, // decoded
	input wire logic [3:0] bank_hit, // banks hit
	input wire logic mr_ext_sel, // extended target
	input wire rdimm_pkg::pwr_type pwr_state_reg, // power state
	input wire logic clk_buf_on // clock buffers
);
	// ****************
	// link and module end checks
	// ****************
	wire logic [3:0] pins = {sel_n, row_n, col_n, wr_n};
	wire logic [3:0] one_hit = 4'h1 << dev_bank_reg;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	chk_reg_clear: assert property (!rst_n |-> dev_cmd_reg == 4'h0 && !dev_cke_reg)
		else $error("input register not cleared");
	chk_one_clock: assert property (rst_n ##1 rst_n |-> dev_cmd_reg == $past(pins)
		&& dev_cke_reg == $past(clk_en)) else $error("register delay wrong");
	chk_sel_masks: assert property (dev_cmd_reg[3] |-> !cmd_fire)
		else $error("deselected command fired");
	chk_bank_route: assert property (cmd_fire && dev_cmd_reg == rdimm_pkg::CMD_ACT
		|-> bank_hit == one_hit) else $error("wrong bank");
	chk_pre_scope: assert property (cmd_fire && dev_cmd_reg == rdimm_pkg::CMD_PRE
		|-> bank_hit == (dev_addr_reg[10] ? 4'hF : one_hit)) else $error("precharge scope");
	chk_mode_target: assert property (cmd_fire && dev_cmd_reg == rdimm_pkg::CMD_MRS
		|-> mr_ext_sel == (dev_bank_reg == rdimm_pkg::MR_EXT)) else $error("mode target");
	chk_pdn_entry: assert property (rst_n && !dev_cke_reg && dev_cmd_reg == 4'h7
		&& pwr_state_reg == rdimm_pkg::PWR_ACTIVE |=> pwr_state_reg inside
		{rdimm_pkg::PWR_PDN_PRE, rdimm_pkg::PWR_PDN_ACT}) else $error("no power-down");
	chk_sr_exit: assert property (pwr_state_reg == rdimm_pkg::PWR_SELF_REF && clk_en
		|-> clk_buf_on ##1 pwr_state_reg == rdimm_pkg::PWR_ACTIVE) else $error("sr exit");
	chk_read_cke: assert property (pins == rdimm_pkg::CMD_RD |-> clk_en [*4])
		else $error("enable dropped during read");
	cover property (cmd_fire && dev_cmd_reg == rdimm_pkg::CMD_ACT);
	cover property (pwr_state_reg == rdimm_pkg::PWR_SELF_REF);
	cover property (!rst_n);
endmodule : rdimm_props
`default_nettype wire

// *** registered_dimm_command_inputs_test.sv ***
// registered_dimm_command_inputs_test: both ends joined, user sides driven.
// assumes ref_clk at 40 MHz; inputs change on falling edges.
`timescale 1ns/1ps
`default_nettype none
`define CK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; \
	$display("[FAIL] %s exp %0h got %0h", n, e, g); end end
module registered_dimm_command_inputs_test;
	logic ref_clk = 1'b0, nrst = 1'b0, hold_reset = 1'b0, req_valid = 1'b0, req_clk_en = 1'b0;
	logic req_ready, rd_expect, dev_cke_reg, dev_clk_on, cmd_buf_on, clk_buf_on, out_drv_on;
	logic cmd_fire, mr_ext_sel;
	logic [3:0] req_cmd = 4'h7, cmd_reg, dev_cmd_reg, bank_hit, open_rows_reg;
	logic [1:0] req_bank = 2'h0, dev_bank_reg;
	logic [12:0] req_addr = 13'h0000, dev_addr_reg;
	rdimm_pkg::pwr_type pwr_state_reg;
	int miscompares = 0, samples_checked = 0;
	cmd_link_if link ();
	rdimm_ctrl_end rdimm_ctrl_end_inst (.ref_clk, .nrst, .link(link.ctrl), .hold_reset,
		.req_valid, .req_ready, .req_cmd, .req_bank, .req_addr, .req_clk_en, .rd_expect, .cmd_reg);
	rdimm_dimm_end rdimm_dimm_end_inst (.ref_clk, .nrst, .link(link.dimm), .dev_cmd_reg,
		.dev_bank_reg, .dev_addr_reg, .dev_cke_reg, .dev_clk_on, .cmd_buf_on, .clk_buf_on,
		.out_drv_on, .cmd_fire, .bank_hit, .mr_ext_sel, .pwr_state_reg, .open_rows_reg);
	rdimm_props rdimm_props_inst (.ref_clk, .nrst, .rst_n(link.rst_n), .sel_n(link.sel_n),
		.row_n(link.row_n), .col_n(link.col_n), .wr_n(link.wr_n), .clk_en(link.clk_en),
		.dev_cmd_reg, .dev_bank_reg, .dev_addr_reg, .dev_cke_reg, .cmd_fire, .bank_hit,
		.mr_ext_sel, .pwr_state_reg, .clk_buf_on);
	// ****************
	// scenarios
	// ****************
	task automatic send(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a);
		req_cmd = c;
		req_bank = b;
		req_addr = a;
		@(negedge ref_clk);
		`CK("ctrl_cmd", c, cmd_reg)
		`CK("ready", 1'b1, req_ready)
		req_cmd = 4'h7;
		@(negedge ref_clk);
		`CK("dev_cmd", c, dev_cmd_reg)
		`CK("dev_bank", b, dev_bank_reg)
		`CK("dev_addr", a, dev_addr_reg)
	endtask : send
	task automatic t_decode();
		for (int i = 0; i < 4; i++) begin
			send(rdimm_pkg::CMD_ACT, 2'(i), 13'h0000);
			`CK("fire", 1'b1, cmd_fire)
			`CK("hit", 4'h1 << i, bank_hit)
		end
		send(rdimm_pkg::CMD_DESEL, 2'h1, 13'h0000);
		`CK("desel", 1'b0, cmd_fire)
		send(rdimm_pkg::CMD_WR, 2'h3, 13'h0000);
		`CK("wr_fire", 1'b1, cmd_fire)
		`CK("wr_hit", 4'h8, bank_hit)
		send(rdimm_pkg::CMD_RD, 2'h2, 13'h0000);
		`CK("rd_early", 1'b0, rd_expect)
		repeat (2) @(negedge ref_clk);
		`CK("rd_due", 1'b1, rd_expect)
		send(rdimm_pkg::CMD_PRE, 2'h1, 13'h0000);
		`CK("pre_one", 4'h2, bank_hit)
	endtask : t_decode
	task automatic t_mode();
		`CK("rows", 4'hD, open_rows_reg)
		send(rdimm_pkg::CMD_PRE, 2'h1, 13'h0400);
		`CK("pre_all", 4'hF, bank_hit)
		send(rdimm_pkg::CMD_MRS, rdimm_pkg::MR_EXT, 13'h0000);
		`CK("mr_ext", 1'b1, mr_ext_sel)
		send(rdimm_pkg::CMD_MRS, rdimm_pkg::MR_BASE, 13'h0000);
		`CK("mr_base", 1'b0, mr_ext_sel)
		`CK("rows_none", 4'h0, open_rows_reg)
	endtask : t_mode
	task automatic t_power(input logic [3:0] c, input rdimm_pkg::pwr_type s);
		req_clk_en = 1'b0;
		send(c, 2'h0, 13'h0000);
		@(negedge ref_clk);
		`CK("pwr", s, pwr_state_reg)
		`CK("cmd_buf", 1'b0, cmd_buf_on)
		`CK("clk_buf", s != rdimm_pkg::PWR_SELF_REF, clk_buf_on)
		`CK("drv", 1'b0, out_drv_on)
		req_clk_en = 1'b1;
		@(negedge ref_clk);
		`CK("wake", 1'b1, clk_buf_on)
		repeat (3) @(negedge ref_clk);
		`CK("active", rdimm_pkg::PWR_ACTIVE, pwr_state_reg)
		`CK("clk_on", 1'b1, dev_clk_on)
		`CK("cmd_buf_on", 1'b1, cmd_buf_on)
		`CK("drv_on", 1'b1, out_drv_on)
	endtask : t_power
	task automatic t_reset();
		hold_reset = 1'b1;
		@(negedge ref_clk);
		`CK("clr_cmd", 4'h0, dev_cmd_reg)
		`CK("clr_cke", 1'b0, dev_cke_reg)
		hold_reset = 1'b0;
		repeat (2) @(negedge ref_clk);
		`CK("rel_cmd", rdimm_pkg::CMD_NOP, dev_cmd_reg)
		`CK("rel_cke", 1'b1, dev_cke_reg)
	endtask : t_reset
	task automatic give_verdict();
		$display("checked %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : give_verdict
	initial forever #12.5 ref_clk = ~ref_clk;
	// about 55 cycles of tests; hang cut after 400
	initial begin
		#10000;
		miscompares++;
		give_verdict();
	end
	initial begin
		repeat (4) @(negedge ref_clk);
		nrst = 1'b1;
		req_valid = 1'b1;
		req_clk_en = 1'b1;
		repeat (2) @(negedge ref_clk);
		t_decode();
		t_power(4'h7, rdimm_pkg::PWR_PDN_ACT);
		t_mode();
		t_power(4'h7, rdimm_pkg::PWR_PDN_PRE);
		t_power(rdimm_pkg::CMD_REF, rdimm_pkg::PWR_SELF_REF);
		t_reset();
		give_verdict();
	end
endmodule : registered_dimm_command_inputs_test
`default_nettype wire
